// ---- hw/ldt_pkg.sv ----
// Shared constants, command codes and carriers for the display timing block
package ldt_pkg;

    // ==========================================================
    // Display geometry
    localparam int         ROW_BITS        = 132;
    localparam int         DRIVE_OUTS      = 133;
    localparam int         ROW_FIFO_DEPTH  = 32;
    localparam logic [6:0] LINES_PER_FRAME = 7'h41;
    localparam logic [6:0] LINE_RESET      = 7'h00;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          LINE_HALF_NS  = 10000;
    localparam logic [15:0] LINE_HALF_CYC = 16'(LINE_HALF_NS / CLK_PERIOD_NS);

    // ==========================================================
    // Power control and volume fields
    localparam int         PWR_BOOST_BIT  = 2;
    localparam int         PWR_REG_BIT    = 1;
    localparam int         PWR_FOLLOW_BIT = 0;
    localparam logic [2:0] PWR_RESET      = 3'h0;
    localparam logic [4:0] VOLUME_RESET   = 5'h00;
    localparam logic [5:0] START_RESET    = 6'h00;

    // ==========================================================
    // Commands
    typedef enum logic [2:0] {
        CMD_NOP        = 3'b000,
        CMD_POWER      = 3'b001,
        CMD_START_LINE = 3'b010,
        CMD_DISP_ON    = 3'b011,
        CMD_REVERSE    = 3'b100,
        CMD_ALL_ON     = 3'b101,
        CMD_VOLUME     = 3'b110
    } ldt_cmd_e;

    typedef struct packed {
        logic     valid;
        ldt_cmd_e kind;
        logic [7:0] data;
    } ldt_cmd_s;

    typedef struct packed {
        logic booster;
        logic regulator;
        logic follower;
    } ldt_pwr_s;

    typedef logic [DRIVE_OUTS-1:0][1:0] ldt_drive_t;

endpackage

// ---- hw/ldt_sync3.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module ldt_sync3 (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Level moves only once the last two stages agree
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_level <= 1'b0;
        end else if (s2_q == s3_q) begin
            o_level <= s3_q;
        end
    end
endmodule

// ---- hw/ldt_fifo.sv ----
// Row buffer FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ldt_fifo #(
    parameter int WIDTH = 132,
    parameter int DEPTH = 32
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign push = i_in_valid && o_in_ready;
    assign pop  = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_q[AW-1:0]];
    assign count_d = (wr_q - rd_q) + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_q        <= '0;
            rd_q        <= '0;
            o_in_ready  <= 1'b0;
            o_out_valid <= 1'b0;
        end else begin
            wr_q        <= wr_q + (AW+1)'(push);
            rd_q        <= rd_q + (AW+1)'(pop);
            o_in_ready  <= count_d != (AW+1)'(DEPTH);
            o_out_valid <= count_d != '0;
        end
    end
endmodule

// ---- hw/ldt_display_timing.sv ----
// Display timing generator, row latch, drive selector and power control
// Function
// - Line clock advances the line counter and strobes the row latch.
// - Each line clock with a 132-bit row waiting latches it onto segment outputs, address in step.
// - Refresh reads run on their own port, independent of host access.
// - Polarity is derived from line clock, alternating over two frames.
// - Slave takes polarity and line clock as inputs and runs from them.
// - Master divides its oscillator into the line clock and drives it out.
// - Polarity toggle gives a common start pulse from the prior trailing edge.
// - Common start output driven only in master mode, released in slave.
// - Master drives polarity, line clock, display off; slave receives all three.
// - Latched row is held for one full common period.
// - Reverse, on/off and all-on act on the latch, never on RAM.
// - Each of 133 outputs selects one of two of four levels: segments level 0 or 1, the common level 2 or 3.
// - Oscillator runs only in master mode.
// - Supply circuits are usable only in master mode.
// - Power command loads booster, regulator, follower enables from D2..D0.
// - Oscillator keeps running while the booster is enabled.
// - Volume of zero switches off the added reference current.
// - Polarity toggle loads the start line; line clock increments it.
`timescale 1ns/100ps
module ldt_display_timing (
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_master_mode,
    input  wire logic                  i_line_clk,
    input  wire logic                  i_polarity,
    input  wire logic                  i_display_off_ctl,
    input  wire ldt_pkg::ldt_cmd_s     i_cmd,
    input  wire logic                  i_row_valid,
    input  wire logic [131:0]          i_row_data,
    output logic                       o_row_ready,
    output logic [6:0]                 o_row_addr,
    output logic                       o_line_clk,
    output logic                       o_line_clk_oe,
    output logic                       o_polarity,
    output logic                       o_polarity_oe,
    output logic                       o_display_off_ctl,
    output logic                       o_display_off_oe,
    output logic                       o_common_start_pulse,
    output logic                       o_common_start_oe,
    output logic [131:0]               o_segment_output,
    output ldt_pkg::ldt_drive_t        o_drive_sel,
    output ldt_pkg::ldt_pwr_s          o_pwr,
    output logic                       o_osc_run,
    output logic                       o_iref_en,
    output logic [4:0]                 o_volume
);
    // ==========================================================
    // Pin synchronisers
    logic master_q;
    logic ext_clk;
    logic ext_pol;
    logic ext_off;
    logic ext_clk_q;
    logic ext_pol_q;

    ldt_sync3 u_sync_mode (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_master_mode),
        .o_level  (master_q)
    );
    ldt_sync3 u_sync_clk (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_line_clk),
        .o_level  (ext_clk)
    );
    ldt_sync3 u_sync_pol (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_polarity),
        .o_level  (ext_pol)
    );
    ldt_sync3 u_sync_off (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_display_off_ctl),
        .o_level  (ext_off)
    );

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_clk_q <= 1'b0;
            ext_pol_q <= 1'b0;
        end else begin
            ext_clk_q <= ext_clk;
            ext_pol_q <= ext_pol;
        end
    end

    // ==========================================================
    // Command registers
    logic [2:0] pwr_q;
    logic [5:0] start_line_q;
    logic       disp_on_q;
    logic       reverse_q;
    logic       all_on_q;
    logic [4:0] volume_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pwr_q        <= ldt_pkg::PWR_RESET;
            start_line_q <= ldt_pkg::START_RESET;
            disp_on_q    <= 1'b0;
            reverse_q    <= 1'b0;
            all_on_q     <= 1'b0;
            volume_q     <= ldt_pkg::VOLUME_RESET;
        end else if (i_cmd.valid) begin
            case (i_cmd.kind)
                ldt_pkg::CMD_POWER:      pwr_q        <= i_cmd.data[2:0];
                ldt_pkg::CMD_START_LINE: start_line_q <= i_cmd.data[5:0];
                ldt_pkg::CMD_DISP_ON:    disp_on_q    <= i_cmd.data[0];
                ldt_pkg::CMD_REVERSE:    reverse_q    <= i_cmd.data[0];
                ldt_pkg::CMD_ALL_ON:     all_on_q     <= i_cmd.data[0];
                ldt_pkg::CMD_VOLUME:     volume_q     <= i_cmd.data[4:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Master line clock divider
    logic [15:0] div_q;
    logic        mclk_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_q  <= 16'h0000;
            mclk_q <= 1'b0;
        end else if (!master_q) begin
            div_q  <= 16'h0000;
            mclk_q <= 1'b0;
        end else if (div_q == ldt_pkg::LINE_HALF_CYC - 16'h0001) begin
            div_q  <= 16'h0000;
            mclk_q <= ~mclk_q;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // ==========================================================
    // Line events: rising edge is the tick, falling edge is trailing
    logic tick;
    logic trail;
    logic mtick;
    logic mtrail;
    logic last_line;
    logic pol_q;
    logic pol_chg;
    logic [6:0] line_cnt_q;

    assign mtick  = master_q && mclk_q == 1'b0 &&
                    div_q == ldt_pkg::LINE_HALF_CYC - 16'h0001;
    assign mtrail = master_q && mclk_q == 1'b1 &&
                    div_q == ldt_pkg::LINE_HALF_CYC - 16'h0001;
    assign tick   = master_q ? mtick : (ext_clk && !ext_clk_q);
    assign trail  = master_q ? mtrail : (!ext_clk && ext_clk_q);
    assign last_line = line_cnt_q == ldt_pkg::LINES_PER_FRAME - 7'h01;
    assign pol_chg = master_q ? (mtick && last_line) : (ext_pol != ext_pol_q);

    // Polarity flips once per frame, so a full cycle spans two frames
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pol_q <= 1'b0;
        end else if (master_q) begin
            if (pol_chg) begin
                pol_q <= ~pol_q;
            end
        end else begin
            pol_q <= ext_pol;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            line_cnt_q <= ldt_pkg::LINE_RESET;
        end else if (pol_chg) begin
            line_cnt_q <= {1'b0, start_line_q};
        end else if (tick) begin
            line_cnt_q <= last_line ? ldt_pkg::LINE_RESET
                                    : line_cnt_q + 7'h01;
        end
    end

    // ==========================================================
    // Row path: refresh port feeds the FIFO, tick pops into the latch
    logic         fifo_valid;
    logic [131:0] fifo_data;
    logic [131:0] latch_q;
    logic         pop;

    assign pop = tick && fifo_valid;

    ldt_fifo #(
        .WIDTH (ldt_pkg::ROW_BITS),
        .DEPTH (ldt_pkg::ROW_FIFO_DEPTH)
    ) u_row_fifo (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_in_valid  (i_row_valid),
        .i_in_data   (i_row_data),
        .o_in_ready  (o_row_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (tick)
    );

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            latch_q    <= '0;
            o_row_addr <= ldt_pkg::LINE_RESET;
        end else if (tick) begin
            if (pop) begin
                latch_q <= fifo_data;
            end
            o_row_addr <= line_cnt_q;
        end
    end

    // ==========================================================
    // Segment data and drive selection
    logic         blank;
    logic [131:0] seg_d;

    assign blank = master_q ? !disp_on_q : ext_off;

    always_comb begin
        if (blank) begin
            seg_d = '0;
        end else if (all_on_q) begin
            seg_d = '1;
        end else begin
            seg_d = reverse_q ? ~latch_q : latch_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_segment_output <= '0;
            o_drive_sel      <= '0;
        end else begin
            o_segment_output <= seg_d;
            for (int i = 0; i < ldt_pkg::ROW_BITS; i++) begin
                o_drive_sel[i] <= {1'b0, seg_d[i] ^ pol_q};
            end
            o_drive_sel[ldt_pkg::ROW_BITS] <= {1'b1, last_line ^ pol_q};
        end
    end

    // ==========================================================
    // Link pins
    logic start_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            start_q <= 1'b0;
        end else if (!master_q) begin
            start_q <= 1'b0;
        end else if (trail) begin
            start_q <= last_line;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_line_clk           <= 1'b0;
            o_line_clk_oe        <= 1'b0;
            o_polarity           <= 1'b0;
            o_polarity_oe        <= 1'b0;
            o_display_off_ctl    <= 1'b0;
            o_display_off_oe     <= 1'b0;
            o_common_start_pulse <= 1'b0;
            o_common_start_oe    <= 1'b0;
        end else begin
            o_line_clk           <= mclk_q;
            o_line_clk_oe        <= master_q;
            o_polarity           <= pol_q;
            o_polarity_oe        <= master_q;
            o_display_off_ctl    <= !disp_on_q;
            o_display_off_oe     <= master_q;
            o_common_start_pulse <= start_q;
            o_common_start_oe    <= master_q;
        end
    end

    // ==========================================================
    // Supply control
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pwr     <= '0;
            o_osc_run <= 1'b0;
            o_iref_en <= 1'b0;
            o_volume  <= ldt_pkg::VOLUME_RESET;
        end else begin
            o_pwr.booster   <= master_q && pwr_q[ldt_pkg::PWR_BOOST_BIT];
            o_pwr.regulator <= master_q && pwr_q[ldt_pkg::PWR_REG_BIT];
            o_pwr.follower  <= master_q && pwr_q[ldt_pkg::PWR_FOLLOW_BIT];
            o_osc_run       <= master_q;
            o_iref_en       <= volume_q != ldt_pkg::VOLUME_RESET;
            o_volume        <= volume_q;
        end
    end

    // ==========================================================
    // Assertions
    AST_LATCH_ON_TICK: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pop |=> latch_q == $past(fifo_data))
        else $error("row not latched on line tick");

    AST_LATCH_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !tick |=> $stable(latch_q))
        else $error("latch changed between ticks");

    AST_LINE_LOAD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pol_chg |=> line_cnt_q == {1'b0, $past(start_line_q)})
        else $error("start line not loaded on polarity change");

    AST_LINE_STEP: assert property (@(posedge i_clk) disable iff (!i_resetn)
        tick && !pol_chg && !last_line |=> line_cnt_q == $past(line_cnt_q) + 7'h01)
        else $error("line counter did not advance");

    AST_SLAVE_RELEASE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !master_q ##1 !master_q |-> !o_common_start_oe && !o_line_clk_oe && !o_polarity_oe)
        else $error("slave drives a link pin");

    AST_POWER_GATE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !master_q |=> o_pwr == '0)
        else $error("supply enabled in slave mode");

    AST_OSC_BOOST: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_pwr.booster |-> o_osc_run)
        else $error("booster on without oscillator");

    AST_IREF_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn)
        volume_q == 5'h00 |=> !o_iref_en)
        else $error("reference current on at zero volume");

    AST_START_PULSE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        master_q && $changed(pol_q) |-> start_q)
        else $error("no start pulse at polarity toggle");

    AST_BLANK: assert property (@(posedge i_clk) disable iff (!i_resetn)
        master_q && !disp_on_q |=> o_segment_output == '0)
        else $error("segments not blanked when display off");
endmodule

// ---- testbench/ldt_link_master_model.sv ----
// Behavioural master-side link source that feeds a display driver in slave mode
`timescale 1ns/100ps
module ldt_link_master_model (
    output logic o_line_clk,
    output logic o_polarity,
    output logic o_display_off_ctl
);
    // ==========================================================
    // Link pins; the line clock stands low between bursts
    initial begin
        o_line_clk        = 1'b0;
        o_polarity        = 1'b0;
        o_display_off_ctl = 1'b0;
    end

    task automatic send_lines(input int n);
        repeat (n) begin
            #62.5 o_line_clk = 1'b1;
            #62.5 o_line_clk = 1'b0;
        end
    endtask

    task automatic flip_polarity();
        #62.5 o_polarity = ~o_polarity;
        #125;
    endtask

    task automatic set_blank(input logic b);
        o_display_off_ctl = b;
        #125;
    endtask
endmodule

// ---- testbench/lcd_display_timing_power_ctl_tb.sv ----
// Self-checking testbench for the display timing and power control block
`timescale 1ns/100ps
module lcd_display_timing_power_ctl_tb;
    typedef struct packed {
        int           due;
        logic [1:0]   sel;
        logic [131:0] val;
    } ldt_note_s;

    logic clk, resetn, mode, row_valid, rev, allon, blank, slave_chk, have_prev;
    logic [131:0] row_data, cur_row, exp_seg;
    logic [3:0] exp_drv;
    logic pol0;
    logic [31:0] lfsr;
    logic [6:0] exp_addr, addr0;
    ldt_pkg::ldt_cmd_s cmd;
    wire  lk, pol, doff;
    logic row_ready, line_clk, line_oe, pol_o, pol_oe, doff_o, doff_oe, csp, csp_oe;
    logic osc_run, iref_en;
    logic [6:0] row_addr;
    logic [4:0] volume;
    logic [131:0] segment_output;
    ldt_pkg::ldt_drive_t drive;
    ldt_pkg::ldt_pwr_s pwr;
    int err_count, checked, cyc, last_cyc, n, i, c0;
    ldt_note_s note_q[$], nt;
    logic [131:0] row_q[$];
    logic [7:0] ptab[4] = '{8'h07, 8'h03, 8'h01, 8'h00};

    ldt_display_timing u_ldt_display_timing (
        .i_clk(clk), .i_resetn(resetn), .i_master_mode(mode), .i_line_clk(lk),
        .i_polarity(pol), .i_display_off_ctl(doff), .i_cmd(cmd), .i_row_valid(row_valid),
        .i_row_data(row_data), .o_row_ready(row_ready), .o_row_addr(row_addr),
        .o_line_clk(line_clk), .o_line_clk_oe(line_oe), .o_polarity(pol_o),
        .o_polarity_oe(pol_oe), .o_display_off_ctl(doff_o), .o_display_off_oe(doff_oe),
        .o_common_start_pulse(csp), .o_common_start_oe(csp_oe), .o_segment_output(segment_output),
        .o_drive_sel(drive), .o_pwr(pwr), .o_osc_run(osc_run), .o_iref_en(iref_en),
        .o_volume(volume)
    );

    ldt_link_master_model u_ldt_link_master_model (
        .o_line_clk(lk), .o_polarity(pol), .o_display_off_ctl(doff)
    );

    // ==========================================================
    // Clock, cycle count, watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    initial begin
        #1000000;
        err_count++;
        wrap_up();
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [131:0] seen, input logic [131:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic issue(input logic [2:0] k, input logic [7:0] d);
        @(posedge clk);
        #1;
        cmd = '{1'b1, ldt_pkg::ldt_cmd_e'(k), d};
        last_cyc = cyc;
        @(posedge clk);
        #1;
        cmd.valid = 1'b0;
    endtask

    task automatic note(input logic [1:0] s, input logic [131:0] v);
        note_q.push_back('{last_cyc + 3, s, v});
    endtask

    task automatic push_row(input logic [131:0] r);
        int g;
        #1;
        row_valid = 1'b1;
        row_data  = r;
        g = 0;
        @(posedge clk);
        while (row_ready !== 1'b1 && g < 100) begin
            @(posedge clk);
            g++;
        end
        row_q.push_back(r);
    endtask

    function automatic logic [131:0] rand_row();
        logic [159:0] w;
        for (int j = 0; j < 5; j++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            w    = {w[127:0], lfsr};
        end
        return w[131:0];
    endfunction

    task automatic wait_rise(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (line_clk !== 1'b0 && c < 5000);
        do begin
            @(negedge clk);
            c++;
        end while (line_clk !== 1'b1 && c < 5000);
    endtask

    // ==========================================================
    // Result watchers: command notes and slave row stream
    always @(negedge clk) begin
        while (note_q.size() > 0 && note_q[0].due <= cyc) begin
            nt = note_q.pop_front();
            case (nt.sel)
                2'd0: chk("power enables", {129'h0, pwr}, nt.val);
                2'd1: chk("iref enable", {131'h0, iref_en}, nt.val);
                2'd2: chk("volume", {127'h0, volume}, nt.val);
                default: chk("display off out", {131'h0, doff_o}, nt.val);
            endcase
        end
    end

    always @(posedge lk) begin
        if (slave_chk) begin
            if (have_prev) begin
                exp_seg = blank ? '0 : allon ? '1 : cur_row ^ {132{rev}};
                chk("segments", segment_output, exp_seg);
                exp_drv = {1'b1, pol, 1'b0, exp_seg[0] ^ pol};
                chk("drive sel", {128'h0, drive[132], drive[0]}, {128'h0, exp_drv});
                chk("row address", {125'h0, row_addr}, {125'h0, exp_addr});
                exp_addr = exp_addr + 7'h01;
            end
            if (row_q.size() > 0) cur_row = row_q.pop_front();
            have_prev = 1'b1;
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        {resetn, mode, row_valid, rev, allon, blank, slave_chk, have_prev} = '0;
        {err_count, checked, cyc} = '0;
        cmd = '0;
        row_data = '0;
        cur_row = '0;
        lfsr = 32'h001c548c;
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        @(negedge clk);
        chk("reset outputs", {123'h0, pwr, volume, iref_en}, '0);
        chk("reset segments", segment_output, '0);
        repeat (8) @(negedge clk);
        chk("slave enables", {128'h0, line_oe, pol_oe, doff_oe, csp_oe}, '0);
        issue(3'h1, 8'h07);
        note(2'd0, 132'h0);
        issue(3'h2, 8'h05);
        issue(3'h3, 8'h01);
        exp_addr = 7'h05;
        u_ldt_link_master_model.flip_polarity();
        repeat (10) @(negedge clk);
        chk("slave oscillator", {131'h0, osc_run}, '0);
        @(posedge clk);
        for (i = 0; i < ldt_pkg::ROW_FIFO_DEPTH; i++) push_row(rand_row());
        #1 row_valid = 1'b0;
        repeat (3) @(posedge clk);
        #1 row_valid = 1'b1;
        row_data = rand_row();
        repeat (4) begin
            @(negedge clk);
            chk("fifo full ready", {131'h0, row_ready}, '0);
        end
        @(posedge clk);
        #1 row_valid = 1'b0;
        slave_chk = 1'b1;
        u_ldt_link_master_model.send_lines(ldt_pkg::ROW_FIFO_DEPTH + 2);
        issue(3'h4, 8'h01);
        rev = 1'b1;
        u_ldt_link_master_model.send_lines(2);
        issue(3'h5, 8'h01);
        allon = 1'b1;
        u_ldt_link_master_model.send_lines(2);
        u_ldt_link_master_model.set_blank(1'b1);
        blank = 1'b1;
        u_ldt_link_master_model.send_lines(2);
        slave_chk = 1'b0;
        u_ldt_link_master_model.set_blank(1'b0);
        issue(3'h5, 8'h00);
        issue(3'h4, 8'h00);
        // Master phase
        @(posedge clk);
        #1 mode = 1'b1;
        repeat (10) @(negedge clk);
        chk("master enables", {128'h0, line_oe, pol_oe, doff_oe, csp_oe}, 132'hf);
        for (i = 0; i < 5; i++) begin
            row_data = rand_row();
            issue(3'h1, (i < 4) ? ptab[i] : row_data[7:0]);
            note(2'd0, (i < 4) ? {129'h0, ptab[i][2:0]} : {129'h0, row_data[2:0]});
        end
        issue(3'h1, 8'h04);
        note(2'd0, 132'h4);
        repeat (4) @(negedge clk);
        chk("oscillator run", {131'h0, osc_run}, 132'h1);
        issue(3'h6, 8'h00);
        note(2'd2, 132'h0);
        note(2'd1, 132'h0);
        row_data = rand_row();
        issue(3'h6, {3'h0, row_data[4:1], 1'b1});
        note(2'd2, {127'h0, row_data[4:1], 1'b1});
        note(2'd1, 132'h1);
        issue(3'h3, 8'h00);
        note(2'd3, 132'h1);
        issue(3'h3, 8'h01);
        note(2'd3, 132'h0);
        issue(3'h7, 8'h00);
        note(2'd3, 132'h0);
        wait_rise(n);
        addr0 = row_addr;
        wait_rise(n);
        chk("line clock period", 132'(n), 132'(2 * ldt_pkg::LINE_HALF_CYC));
        chk("line step", {125'h0, row_addr}, {125'h0, addr0 + 7'h01});
        // Run to the frame end: start pulse leads the polarity flip by half a line
        pol0 = pol_o;
        c0 = 0;
        n = 0;
        while (pol_o === pol0 && n < 45000) begin
            @(negedge clk);
            n++;
            if (csp === 1'b1 && c0 == 0) c0 = cyc;
        end
        chk("start lead", 132'(cyc - c0), 132'(ldt_pkg::LINE_HALF_CYC));
        chk("start pulse", {131'h0, csp}, 132'h1);
        repeat (5) @(negedge clk);
        wrap_up();
    end
endmodule
